// ---- dv/pmdis_bank_chk.sv ----
// checker for the module disable bank, port view only
// assumes a bind onto every pmdis_bank instance
`include "pmdis_consts.vh"
module pmdis_chk #(
    parameter ADDR_W = 12                   // apb address width
) (
    input wire              pclk,
    input wire              presetn,
    input wire              clk_en,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire [5:0]        periph_wr_req,
    input wire [5:0]        periph_rst_n,
    input wire [5:0]        periph_wr_en,
    input wire              eeprom_power_off
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a lane may write only while it is out of reset
    property gate_p(int i);
        $past(clk_en) |->
            periph_wr_en[i] == ($past(periph_wr_req[i]) && periph_rst_n[i]);
    endproperty
    capture_gate_a: assert property (gate_p(1)) else $error("lane 1 gate");
    compare_gate_a: assert property (gate_p(0)) else $error("lane 0 gate");
    refclk_gate_a: assert property (gate_p(4)) else $error("lane 4 gate");
    charge_gate_a: assert property (gate_p(3)) else $error("lane 3 gate");
    voltage_gate_a: assert property (gate_p(2)) else $error("lane 2 gate");
    // unassigned bits never read back as one
    two_unused_a: assert property (pready && paddr == `PMDIS_OFF_DIS_TWO |->
        (prdata & ~{16'h0000, `PMDIS_MASK_TWO}) == 32'h0)
        else $error("two upper bits");
    four_unused_a: assert property (pready && paddr == `PMDIS_OFF_DIS_FOUR |->
        (prdata & ~{16'h0000, `PMDIS_MASK_FOUR}) == 32'h0)
        else $error("four upper bits");
    // array power gate and lane reset come from the same bit
    eeprom_gate_a: assert property ($past(presetn) |->
        eeprom_power_off != periph_rst_n[5]) else $error("eeprom gate");
    cover property (!periph_rst_n[1]);
    cover property (eeprom_power_off);
    cover property (pready && paddr == `PMDIS_OFF_DIS_FOUR);
endmodule // pmdis_chk
bind pmdis_bank pmdis_chk #(.ADDR_W(ADDR_W)) pmdis_chk_inst (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .prdata(prdata),
    .pready(pready), .periph_wr_req(periph_wr_req),
    .periph_rst_n(periph_rst_n), .periph_wr_en(periph_wr_en),
    .eeprom_power_off(eeprom_power_off));

// ---- dv/pmdis_bank_tb.sv ----
// self-checking bench for the module disable bank
// assumes an apb slave on pclk; clk_en drops once to test the freeze
`include "pmdis_consts.vh"
module pmdis_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        eeprom_power_off, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  periph_wr_req, periph_rst_n, periph_wr_en;
    logic [15:0] two, four;                 // bench image of the registers
    int          errors, compares;
    pmdis_bank pmdis_bank_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_wr_req(periph_wr_req),
        .periph_rst_n(periph_rst_n), .periph_wr_en(periph_wr_en),
        .eeprom_power_off(eeprom_power_off));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // lanes out of reset for given disable words
    function automatic logic [5:0] lanes(logic [15:0] a, logic [15:0] b);
        return ~{b[4], b[3], b[2], b[1], a[8], a[0]};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one transfer; the request stands until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write, read back, then look at every lane output
    task automatic wr_chk(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
        if (a == `PMDIS_OFF_DIS_TWO) two = d[15:0] & `PMDIS_MASK_TWO;
        else four = d[15:0] & `PMDIS_MASK_FOUR;
        apb(1'b0, a, 32'h0);
        chk("readback", {16'h0, a == 12'h000 ? two : four}, rd);
        periph_wr_req <= 6'($urandom);
        @(posedge pclk);
        #1;
        chk("lane reset", lanes(two, four), periph_rst_n);
        chk("permit", periph_wr_req & lanes(two, four), periph_wr_en);
        chk("eeprom gate", four[4], eeprom_power_off);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, periph_wr_req} = '0;
        {presetn, two, four, errors, compares} = '0;
        clk_en = 1'b1;
        void'($urandom(32'ha069918f));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("reset lanes", 6'h3f, periph_rst_n);
        apb(1'b0, `PMDIS_OFF_DIS_TWO, 32'h0);
        chk("reset two", 32'h0, rd);
        apb(1'b0, `PMDIS_OFF_DIS_FOUR, 32'h0);
        chk("reset four", 32'h0, rd);
        $display("reset test done");
        wr_chk(`PMDIS_OFF_DIS_TWO, 32'hffffffff);
        wr_chk(`PMDIS_OFF_DIS_FOUR, 32'hffffffff);
        repeat (24) wr_chk({9'h0, 1'($urandom), 2'h0}, $urandom);
        $display("random test done");
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, `PMDIS_OFF_STATUS, 32'h0);
        chk("status", {26'h0, ~lanes(two, four)}, rd);
        $display("refusal test done");
        // clock enable low: lane permits must not follow new requests
        clk_en <= 1'b0;
        periph_wr_req <= ~periph_wr_req;
        repeat (3) @(posedge pclk);
        #1;
        chk("frozen permit", (~periph_wr_req) & lanes(two, four), periph_wr_en);
        clk_en <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        #1;
        chk("thawed permit", periph_wr_req & lanes(two, four), periph_wr_en);
        $display("freeze test done");
        end_sim();
    end
endmodule // pmdis_bank_tb

// ---- hdl/pmdis_bank.v ----
// peripheral module disable bank with apb register access
// assumes an apb master on pclk; peripherals take the gate outputs
`include "pmdis_consts.vh"

module pmdis_bank #(
    parameter ADDR_W = 12                  // apb address width
) (
    pclk,
    presetn,
    clk_en,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    periph_wr_req,
    periph_rst_n,
    periph_wr_en,
    eeprom_power_off
);
    input  wire              pclk;            // system clock
    input  wire              presetn;         // async reset, active low
    input  wire              clk_en;          // freezes all state when low
    input  wire              psel;            // apb select
    input  wire              penable;         // apb access phase
    input  wire              pwrite;          // apb direction
    input  wire [ADDR_W-1:0] paddr;           // apb byte address
    input  wire [31:0]       pwdata;          // apb write data
    output reg  [31:0]       prdata;          // apb read data
    output reg               pready;          // apb ready
    output reg               pslverr;         // apb error, unmapped or status write
    input  wire [5:0]        periph_wr_req;   // per-lane write attempts
    output wire [5:0]        periph_rst_n;    // per-lane resets, low active
    output wire [5:0]        periph_wr_en;    // per-lane write permits
    output reg               eeprom_power_off; // eeprom array gated

    // lane order: 0 compare, 1 capture, 2 voltage, 3 charge,
    // 4 refclk, 5 eeprom

    reg  [15:0] dis_two_reg;   // module_disable_two
    reg  [15:0] dis_four_reg;  // module_disable_four
    reg  [15:0] dis_two_next;
    reg  [15:0] dis_four_next;
    reg  [31:0] prdata_next;
    reg         pslverr_next;
    reg         pready_next;
    wire [5:0]  lane_dis;      // disable level per lane
    wire        acc;           // access phase

    // address decode, shared by read and write paths
    function [1:0] dec;
        input [ADDR_W-1:0] a;
        begin
            if (a == `PMDIS_OFF_DIS_TWO)
                dec = 2'h1;
            else if (a == `PMDIS_OFF_DIS_FOUR)
                dec = 2'h2;
            else if (a == `PMDIS_OFF_STATUS)
                dec = 2'h3;
            else
                dec = 2'h0;
        end
    endfunction

    // one-wait slave: registered pready answers in the second access cycle
    assign acc = psel & penable & ~pready;

    // write path; masks keep unassigned bits at zero
    always @* begin
        dis_two_next  = dis_two_reg;
        dis_four_next = dis_four_reg;
        if (acc && pwrite) begin
            case (dec(paddr))
                2'h1: begin
                    dis_two_next = pwdata[15:0] & `PMDIS_MASK_TWO;
                end
                2'h2: begin
                    dis_four_next = pwdata[15:0] & `PMDIS_MASK_FOUR;
                end
                default: begin
                    dis_two_next = dis_two_reg;
                end
            endcase
        end
    end

    // read path and error answer; status is read-only
    always @* begin
        prdata_next  = 32'h00000000;
        pslverr_next = 1'b0;
        pready_next  = acc;
        if (acc) begin
            case (dec(paddr))
                2'h1: begin
                    prdata_next = {16'h0000, dis_two_reg};
                end
                2'h2: begin
                    prdata_next = {16'h0000, dis_four_reg};
                end
                2'h3: begin
                    // live lane reset state, shows the gating took hold
                    prdata_next = {26'h0, ~periph_rst_n};
                    pslverr_next = pwrite;
                end
                default: begin
                    pslverr_next = 1'b1;
                end
            endcase
        end
    end

    // register state; all bits clear so every module starts enabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_two_reg      <= `PMDIS_RST_TWO;
            dis_four_reg     <= `PMDIS_RST_FOUR;
            prdata           <= 32'h00000000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            eeprom_power_off <= 1'b0;
        end else if (clk_en) begin
            dis_two_reg      <= dis_two_next;
            dis_four_reg     <= dis_four_next;
            prdata           <= prdata_next;
            pready           <= pready_next;
            pslverr          <= pslverr_next;
            // array power follows the eeprom bit
            eeprom_power_off <= dis_four_reg[`PMDIS_BIT_EEPROM];
        end
    end

    // map register bits onto lanes
    assign lane_dis[0] = dis_two_reg[`PMDIS_BIT_COMPARE];
    assign lane_dis[1] = dis_two_reg[`PMDIS_BIT_CAPTURE];
    assign lane_dis[2] = dis_four_reg[`PMDIS_BIT_VOLTAGE];
    assign lane_dis[3] = dis_four_reg[`PMDIS_BIT_CHARGE];
    assign lane_dis[4] = dis_four_reg[`PMDIS_BIT_REFCLK];
    assign lane_dis[5] = dis_four_reg[`PMDIS_BIT_EEPROM];

    // one gate per lane: reset hold and write block
    genvar gi;
    generate
        for (gi = 0; gi < `PMDIS_NUM_MODS; gi = gi + 1) begin : g_lane
            pmdis_gate u_gate (
                .pclk       (pclk),
                .presetn    (presetn),
                .clk_en     (clk_en),
                .disable_in (lane_dis[gi]),
                .wr_req     (periph_wr_req[gi]),
                .hold_rst_n (periph_rst_n[gi]),
                .wr_allow   (periph_wr_en[gi])
            );
        end
    endgenerate
endmodule // pmdis_bank

// ---- hdl/pmdis_consts.vh ----
// constants for the peripheral module disable bank
// assumes a 32-bit apb slave with word-aligned registers
`ifndef PMDIS_CONSTS_VH
`define PMDIS_CONSTS_VH

// register byte offsets
`define PMDIS_OFF_DIS_TWO      12'h000
`define PMDIS_OFF_DIS_FOUR     12'h004
`define PMDIS_OFF_STATUS       12'h008

// field positions in module_disable_two
`define PMDIS_BIT_CAPTURE      8
`define PMDIS_BIT_COMPARE      0

// field positions in module_disable_four
`define PMDIS_BIT_EEPROM       4
`define PMDIS_BIT_REFCLK       3
`define PMDIS_BIT_CHARGE       2
`define PMDIS_BIT_VOLTAGE      1

// implemented-bit masks and reset values
`define PMDIS_MASK_TWO         16'h0101
`define PMDIS_MASK_FOUR        16'h001e
`define PMDIS_RST_TWO          16'h0000
`define PMDIS_RST_FOUR         16'h0000

// number of peripheral gate lanes
`define PMDIS_NUM_MODS         6

`endif

// ---- hdl/pmdis_gate.v ----
// one peripheral gating lane: reset hold and write block
// assumes the disable level comes from a register on the same clock
module pmdis_gate (
    pclk,
    presetn,
    clk_en,
    disable_in,
    wr_req,
    hold_rst_n,
    wr_allow
);
    input  wire pclk;        // system clock
    input  wire presetn;     // async reset, active low
    input  wire clk_en;      // freezes state while low
    input  wire disable_in;  // module disable level
    input  wire wr_req;      // peripheral write attempt
    output reg  hold_rst_n;  // peripheral reset, active low
    output reg  wr_allow;    // registered write permission

    // registered so the peripheral sees glitch-free controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_rst_n <= 1'b0;
            wr_allow   <= 1'b0;
        end else if (clk_en) begin
            // disabled: held in reset, writes dropped
            hold_rst_n <= ~disable_in;
            wr_allow   <= wr_req & ~disable_in;
        end
    end
endmodule // pmdis_gate
